// ### core/rivm_core.sv
`timescale 1ns/100ps
// How it works
// - Any reset with fuse unprogrammed starts execution at word 0x0000.
// - External request zero vectors to table base, address 0x0002.
// - Pin change groups A and B vector to 0x0004 and 0x0006.
// - Timer 2, timer 1, timer 0 vectors from 0x0008, 0x000C, 0x0014.
// - Synchronous serial transfer complete vectors to 0x0018.
// - Async serial receive, empty, transmit vector to 0x001A-0x001E.
// - Universal serial start and overflow vector to 0x0020, 0x0022.
// - Comparator, converter, data memory ready at 0x0024-0x0028.
// - Store ready at 0x002A, display frame start last at 0x002C.
// - Programmed fuse starts any reset at the boot loader address.
// - Select bit set adds boot section start to each interrupt vector.
// - Table base is 0x0002, or boot address plus 0x0002.
// - Fuse value 1 is unprogrammed, 0 is programmed.
// - Select changes need enable then write within four cycles.
module rivm_core #(
    parameter int                       AW        = rivm_pkg::ADDR_W,
    parameter int                       NIRQ      = rivm_pkg::NUM_IRQ,
    parameter logic [rivm_pkg::ADDR_W-1:0] BOOT_ADDR = 14'h1C00
) (
    input  wire logic              clk_sys,        // System clock
    input  wire logic              nrst,           // Async reset, low
    input  wire logic              boot_reset_fuse, // Fuse, 1 = unprog.
    input  wire logic [NIRQ-1:0]   irq_req,        // Request lines
    input  wire logic              gie,            // Core global enable
    input  wire logic              vsel_wr,        // Control write strobe
    input  wire logic              vsel_wr_ce,     // Written change enable
    input  wire logic              vsel_wr_sel,    // Written select value
    input  wire logic              instr_done,     // Instruction retired
    output logic [AW-1:0]          reset_addr,     // Reset entry address
    output logic [AW-1:0]          table_base,     // Table start address
    output logic                   irq_valid,      // Request to take
    output logic [AW-1:0]          irq_addr,       // Vector address
    output logic [4:0]             irq_vec_num,    // Vector number
    output logic                   vec_sel,        // Select bit state
    output logic                   vec_chg_en,     // Change enable state
    output logic                   irq_holdoff     // Interrupts held off
);
    initial begin
        if (AW != rivm_pkg::ADDR_W || NIRQ != rivm_pkg::NUM_IRQ) begin
            $error("rivm_core: width or request count unsupported");
        end
    end

    logic [2:0]                   chg_cnt;
    logic                         post_wr;
    logic                         any_req;
    logic [rivm_pkg::IDX_W-1:0]   win_idx;
    logic [AW-1:0]                next_base;
    logic [AW-1:0]                next_vaddr;
    logic                         hold_now;

    // Fuse is a static level, so the reset entry follows it directly
    always_comb begin
        if (boot_reset_fuse == rivm_pkg::FUSE_PROGRAMMED) begin
            reset_addr = BOOT_ADDR;
        end else begin
            reset_addr = rivm_pkg::RESET_ADDR_APP;
        end
    end

    // Change-enable window and select bit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            chg_cnt <= 3'h0;
        end else if (vsel_wr && vsel_wr_ce) begin
            chg_cnt <= rivm_pkg::CHG_WINDOW_CNT;
        end else if (vsel_wr) begin
            chg_cnt <= 3'h0;
        end else if (chg_cnt != 3'h0) begin
            chg_cnt <= chg_cnt - 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vec_sel <= 1'b0;
        end else if (vsel_wr && !vsel_wr_ce && chg_cnt != 3'h0) begin
            vec_sel <= vsel_wr_sel;
        end
    end

    // Hold off through the instruction after the select write
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            post_wr <= 1'b0;
        end else if (vsel_wr && !vsel_wr_ce && chg_cnt != 3'h0) begin
            post_wr <= 1'b1;
        end else if (instr_done) begin
            post_wr <= 1'b0;
        end
    end

    assign vec_chg_en  = (chg_cnt != 3'h0);
    assign hold_now    = vec_chg_en || post_wr;
    assign irq_holdoff = hold_now;

    always_comb begin
        if (vec_sel) begin
            next_base = BOOT_ADDR + rivm_pkg::TABLE_OFS_BOOT;
        end else begin
            next_base = rivm_pkg::TABLE_BASE_APP;
        end
    end

    rivm_prio #(
        .N  (NIRQ),
        .IW (rivm_pkg::IDX_W)
    ) u_prio (
        .req (irq_req),
        .any (any_req),
        .idx (win_idx)
    );

    assign next_vaddr = next_base
                      + AW'({win_idx, 1'b0});

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            table_base  <= rivm_pkg::TABLE_BASE_APP;
            irq_addr    <= rivm_pkg::TABLE_BASE_APP;
            irq_vec_num <= rivm_pkg::VEC_NUM_RESET;
            irq_valid   <= 1'b0;
        end else begin
            table_base  <= next_base;
            irq_addr    <= next_vaddr;
            irq_vec_num <= rivm_pkg::VEC_NUM_FIRST + win_idx;
            irq_valid   <= any_req && gie && !hold_now;
        end
    end
endmodule

// ### core/rivm_pkg.sv
package rivm_pkg;
    localparam int ADDR_W     = 14;
    localparam int NUM_IRQ    = 22;
    localparam int IDX_W      = 5;

    // Reset and table placement
    localparam logic [13:0] RESET_ADDR_APP = 14'h0000;
    localparam logic [13:0] TABLE_BASE_APP = 14'h0002;
    localparam logic [13:0] TABLE_OFS_BOOT = 14'h0002;
    localparam logic [13:0] VEC_STRIDE     = 14'h0002;

    // Fuse encoding
    localparam logic FUSE_UNPROGRAMMED = 1'b1;
    localparam logic FUSE_PROGRAMMED   = 1'b0;

    // Request line positions (line n vectors to table base + 2*n)
    localparam int IRQ_EXT0    = 0;
    localparam int IRQ_PCA     = 1;
    localparam int IRQ_PCB     = 2;
    localparam int IRQ_T2_CMP  = 3;
    localparam int IRQ_T2_OVF  = 4;
    localparam int IRQ_T1_CAP  = 5;
    localparam int IRQ_T1_CMPA = 6;
    localparam int IRQ_T1_CMPB = 7;
    localparam int IRQ_T1_OVF  = 8;
    localparam int IRQ_T0_CMP  = 9;
    localparam int IRQ_T0_OVF  = 10;
    localparam int IRQ_SSP_TC  = 11;
    localparam int IRQ_ASP_RX  = 12;
    localparam int IRQ_ASP_DRE = 13;
    localparam int IRQ_ASP_TX  = 14;
    localparam int IRQ_USU_ST  = 15;
    localparam int IRQ_USU_OVF = 16;
    localparam int IRQ_ACMP    = 17;
    localparam int IRQ_CONV    = 18;
    localparam int IRQ_NVM_RDY = 19;
    localparam int IRQ_SPS_RDY = 20;
    localparam int IRQ_DISP_SF = 21;

    // Vector numbers: reset is 1, first request is 2, last is 23
    localparam logic [4:0] VEC_NUM_RESET = 5'h01;
    localparam logic [4:0] VEC_NUM_FIRST = 5'h02;

    // Guarded change window in cycles
    localparam int          CHG_WINDOW     = 4;
    localparam logic [2:0]  CHG_WINDOW_CNT = 3'h4;
endpackage

// ### core/rivm_prio.sv
`timescale 1ns/100ps
module rivm_prio #(
    parameter int N   = 22,
    parameter int IW  = 5
) (
    input  wire logic [N-1:0]  req,    // Pending request lines
    output logic               any,    // Some request pending
    output logic [IW-1:0]      idx     // Lowest pending index
);
    initial begin
        if (N < 1 || (1 << IW) < N) begin
            $error("rivm_prio: index width too small");
        end
    end

    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = IW'(i);
            end
        end
    end
endmodule

// ### sim/rivm_core_monitor.sv
`timescale 1ns/100ps
module rivm_core_monitor #(
    parameter logic [13:0] BOOT_ADDR = 14'h1C00
) (
    input wire logic        clk_sys,         // Clock
    input wire logic        nrst,            // Reset
    input wire logic        boot_reset_fuse, // Fuse
    input wire logic [21:0] irq_req,         // Requests
    input wire logic        gie,             // Enable
    input wire logic        vsel_wr,         // Write
    input wire logic        vsel_wr_ce,      // Change enable
    input wire logic        vsel_wr_sel,     // Select
    input wire logic [13:0] reset_addr,      // Reset entry
    input wire logic [13:0] table_base,      // Base
    input wire logic        irq_valid,       // Valid
    input wire logic [13:0] irq_addr,        // Vector
    input wire logic [4:0]  irq_vec_num,     // Number
    input wire logic        vec_sel,         // Select state
    input wire logic        vec_chg_en,      // Window open
    input wire logic        irq_holdoff      // Hold-off
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    chk_reset_entry: assert property (
        reset_addr == (boot_reset_fuse ? 14'h0000 : BOOT_ADDR))
        else $error("reset entry wrong");
    chk_table_base: assert property (vec_sel == $past(vec_sel) |->
        table_base == (vec_sel ? BOOT_ADDR + 14'h0002 : 14'h0002))
        else $error("table base wrong");
    chk_vec_addr: assert property (
        irq_valid |-> irq_addr == $past(table_base)
        + {8'h00, irq_vec_num - 5'h02, 1'b0}) else $error("vector wrong");
    chk_lowest_wins: assert property (irq_valid |->
        ({10'h000, $past(irq_req)} & ((32'h1 << (irq_vec_num - 5'h01))
        - 32'h1)) == (32'h1 << (irq_vec_num - 5'h02)))
        else $error("priority wrong");
    chk_valid_cause: assert property (
        irq_valid == $past((|irq_req) && gie && !irq_holdoff))
        else $error("valid wrong");
    chk_open_window: assert property (
        vsel_wr && vsel_wr_ce |=> vec_chg_en && irq_holdoff)
        else $error("window not opened");
    chk_sel_update: assert property (vsel_wr && !vsel_wr_ce && vec_chg_en
        |=> vec_sel == $past(vsel_wr_sel) && !vec_chg_en && irq_holdoff)
        else $error("select not taken");
    chk_window_ends: assert property (
        vsel_wr && vsel_wr_ce ##1 !vsel_wr [*4] |=> !vec_chg_en)
        else $error("window too long");
    cover property (irq_valid && irq_vec_num == 5'h17);
    cover property (vsel_wr && !vsel_wr_ce && vec_chg_en);
    cover property (irq_valid && vec_sel);
endmodule
bind rivm_core rivm_core_monitor #(.BOOT_ADDR(BOOT_ADDR)) u_mon (.*);

// ### sim/rivm_fetch_model.sv
`timescale 1ns/100ps
module rivm_fetch_model (
    input wire logic clk_sys,   // Clock
    input wire logic nrst,      // Reset
    input wire logic slow,      // Retire every fourth cycle
    output logic     instr_done // Retire pulse
);
    logic [1:0] cnt;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            cnt <= 2'h0;
        else
            cnt <= cnt + 2'h1;
    end
    assign instr_done = slow ? (cnt == 2'h3) : 1'b1;
endmodule

// ### sim/reset_interrupt_vector_map_bench.sv
`timescale 1ns/100ps
module reset_interrupt_vector_map_bench;
    localparam logic [13:0] BA = 14'h3800;
    logic        clk_sys = 1'b0, nrst = 1'b0, fuse = 1'b1, gie = 1'b0;
    logic        wr = 1'b0, ce = 1'b0, wsel = 1'b0, slow = 1'b0, done;
    logic [21:0] req = 22'h000000;
    logic [13:0] rst_a, base, addr;
    logic [4:0]  num;
    logic        valid, sel, chg, hold;
    logic [31:0] r;
    int          seed = 48, error_cnt = 0, cmp_count = 0, cyc = 0;
    int          cnt, post, msel, ev, ea, en, hp, eb, dn;
    rivm_core #(.BOOT_ADDR(BA)) u_rivm_core (.clk_sys(clk_sys), .nrst(nrst),
        .boot_reset_fuse(fuse), .irq_req(req), .gie(gie), .vsel_wr(wr),
        .vsel_wr_ce(ce), .vsel_wr_sel(wsel), .instr_done(done),
        .reset_addr(rst_a), .table_base(base), .irq_valid(valid),
        .irq_addr(addr), .irq_vec_num(num), .vec_sel(sel),
        .vec_chg_en(chg), .irq_holdoff(hold));
    rivm_fetch_model u_rivm_fetch_model (.clk_sys(clk_sys), .nrst(nrst),
        .slow(slow), .instr_done(done));
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    initial begin
        for (int n = 0; n < 3000; n++) begin
            @(negedge clk_sys) dn = done;
            @(posedge clk_sys);
            #1;
            hp = (cnt != 0) || post;
            eb = (nrst && msel) ? BA + 2 : 2;
            ev = nrst && req != 0 && gie && !hp;
            for (int i = 21; i >= 0; i--)
                if (req[i]) en = i + 2;
            ea = (msel ? BA + 2 : 2) + 2 * (en - 2);
            if (post && dn) post = 0;
            if (!nrst) begin
                cnt = 0;
                post = 0;
                msel = 0;
            end else if (wr && ce) cnt = 4;
            else if (wr && cnt != 0) begin
                msel = wsel;
                cnt = 0;
                post = 1;
            end else if (cnt != 0) cnt--;
            check(rst_a, fuse ? 14'h0000 : BA);
            check(base, 14'(eb));
            check({sel, chg, hold, valid},
                {msel[0], cnt != 0, cnt != 0 || post != 0, ev[0]});
            if (ev) check(addr, 14'(ea));
            if (ev) check({9'h000, num}, 14'(en));
            r = $random(seed);
            nrst = !(n < 16 || (n >= 1500 && n < 1503));
            gie = n < 60 || r[0] || r[1];
            fuse = n < 60 || r[27];
            req = n < 60 ? 22'h1 << (n % 22) : r[21:0] << r[26:22];
            wr = n >= 60 && r[28] && r[29];
            ce = r[30];
            wsel = r[31];
            slow = n > 1000;
            if (n < 17 || (n >= 1500 && n < 1504)) begin
                req = 22'h000000;
                wr = 1'b0;
            end
        end
        tally_and_finish;
    end
endmodule
